// *** core/tca_decoder.sv ***
// Purpose: Decode command word A ahead of each transmit buffer and trim its data
// Assumes: One dword per din_valid cycle; command A, command B, then data
// Notes:   Output is one dword per cycle with byte enables, never stalls
// Function
// - Interrupt-on-completion bit 31 sets the buffer-done flag after the whole buffer
// - Buffer-done flag reaches the interrupt only when its enable bit is set
// - Bits 25:24 select 4, 16 or 32 byte end alignment; 11 reserved
// - Filler dwords are consumed and never reach the output
// - Bits 20:16 give the first valid byte; earlier bytes are skipped
// - Offset low bits pick the byte lane, upper bits skip whole dwords
// - Bit 13 marks first segment, bit 12 marks last segment
// - Byte counts summed per packet; mismatch with packet length raises error
// - Buffer data starts at the third dword, after commands A and B
`timescale 1ns/100ps
module tca_decoder
  import tca_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  input  wire logic        din_valid,
  input  wire logic [31:0] din_data,
  output logic             out_valid_q,
  output logic      [31:0] out_data_q,
  output logic      [3:0]  out_be_q,
  output logic             out_sof_q,
  output logic             out_eof_q,
  output logic             irq_q
);
  tca_state_type state_q, state_d;
  logic        ioc_q, ioc_d, first_q, first_d, ls_q, ls_d, bad_q, bad_d, sofp_q, sofp_d;
  logic [1:0]  align_q, align_d;
  logic [4:0]  ofs_q, ofs_d;
  logic [10:0] size_q, size_d, words_q, words_d, dw_q, dw_d;
  logic [11:0] end_q, end_d, sum_q, sum_d;
  logic        out_valid_d, out_sof_d, out_eof_d;
  logic [3:0]  out_be_d;
  logic [INT_W-1:0] sts, sts_set, sts_clr, int_en_q, int_en_d;
  logic        irq_d;
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d;

  // Next-state of the command and data path
  always_comb begin
    logic [10:0] words;
    logic [10:0] mask;
    logic [10:0] last_dw;
    logic [12:0] pos;
    words = 11'((13'(end_q) + 13'd3) >> 2);
    mask = DW_MASK_4;
    last_dw = 11'((end_q - 12'd1) >> 2);
    pos = 13'h0;
    state_d = state_q;
    ioc_d = ioc_q;
    first_d = first_q;
    ls_d = ls_q;
    bad_d = bad_q;
    sofp_d = sofp_q;
    align_d = align_q;
    ofs_d = ofs_q;
    size_d = size_q;
    words_d = words_q;
    dw_d = dw_q;
    end_d = end_q;
    sum_d = sum_q;
    out_valid_d = 1'b0;
    out_be_d = 4'h0;
    out_sof_d = 1'b0;
    out_eof_d = 1'b0;
    sts_set = '0;
    case (align_q)
      ALIGN_16: mask = DW_MASK_16;
      ALIGN_32: mask = DW_MASK_32;
      default:  mask = DW_MASK_4;                      // Reserved is dropped anyway
    endcase
    if (din_valid) begin
      case (state_q)
        ST_CMD_A: begin
          // Reserved bits 30:26, 23:21, 15:14 are simply never looked at
          ioc_d = din_data[IOC_BIT];
          align_d = din_data[ALIGN_HI:ALIGN_LO];
          ofs_d = din_data[OFS_HI:OFS_LO];
          first_d = din_data[FIRST_SEG_BIT];
          ls_d = din_data[LS_BIT];
          size_d = din_data[SIZE_HI:0];
          end_d = 12'(din_data[OFS_HI:OFS_LO]) + 12'(din_data[SIZE_HI:0]);
          sum_d = din_data[FIRST_SEG_BIT] ? 12'(din_data[SIZE_HI:0])
                                   : sum_q + 12'(din_data[SIZE_HI:0]);
          bad_d = (din_data[ALIGN_HI:ALIGN_LO] == ALIGN_RSV);
          sts_set[INT_ERR] = bad_d;
          state_d = ST_CMD_B;
        end
        ST_CMD_B: begin
          // Padded dword count of the data area
          words_d = (words + mask) & ~mask;
          dw_d = 11'h000;
          sofp_d = first_q;
          if (ls_q && (sum_q != 12'(din_data[SIZE_HI:0]))) begin
            sts_set[INT_ERR] = 1'b1;
          end
          if (words_d == 11'h000) begin
            sts_set[INT_DONE] = ioc_q;
            state_d = ST_CMD_A;
          end else begin
            state_d = ST_DATA;
          end
        end
        ST_DATA: begin
          // Keep only bytes inside [offset, offset+size)
          for (int b = 0; b < 4; b++) begin
            pos = {dw_q, 2'b00} + 13'(b);
            out_be_d[b] = (pos >= 13'(ofs_q)) && (pos < 13'(end_q));
          end
          out_valid_d = (|out_be_d) && !bad_q;
          out_sof_d = out_valid_d && sofp_q;
          out_eof_d = out_valid_d && ls_q && (dw_q == last_dw);
          if (out_valid_d) begin
            sofp_d = 1'b0;
          end
          dw_d = dw_q + 11'h001;
          if (dw_d == words_q) begin
            sts_set[INT_DONE] = ioc_q;
            state_d = ST_CMD_A;
          end
        end
        default: state_d = ST_CMD_A;
      endcase
    end
  end

  // Command and data path registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_CMD_A;
      ioc_q <= 1'b0;
      first_q <= 1'b0;
      ls_q <= 1'b0;
      bad_q <= 1'b0;
      sofp_q <= 1'b0;
      align_q <= ALIGN_4;
      ofs_q <= 5'h00;
      size_q <= 11'h000;
      words_q <= 11'h000;
      dw_q <= 11'h000;
      end_q <= 12'h000;
      sum_q <= 12'h000;
      out_valid_q <= 1'b0;
      out_data_q <= ZERO32;
      out_be_q <= 4'h0;
      out_sof_q <= 1'b0;
      out_eof_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      ioc_q <= ioc_d;
      first_q <= first_d;
      ls_q <= ls_d;
      bad_q <= bad_d;
      sofp_q <= sofp_d;
      align_q <= align_d;
      ofs_q <= ofs_d;
      size_q <= size_d;
      words_q <= words_d;
      dw_q <= dw_d;
      end_q <= end_d;
      sum_q <= sum_d;
      out_valid_q <= out_valid_d;
      out_data_q <= din_data;
      out_be_q <= out_be_d;
      out_sof_q <= out_sof_d;
      out_eof_q <= out_eof_d;
    end
  end

  // Done and error flags, write one to clear
  tca_sticky #(
    .W (INT_W)
  ) u_sts (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set     (sts_set),
    .clr     (sts_clr),
    .flag_q  (sts)
  );

  // APB slave: one wait state, writes land on the edge pready is seen high
  always_comb begin
    logic acc;
    logic wr;
    acc = psel && penable;
    wr = acc && pready_q && pwrite;
    sts_clr = '0;
    int_en_d = int_en_q;
    pready_d = acc && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = ZERO32;
    if (wr && (paddr == OFF_INT_STS)) begin
      sts_clr = pwdata[INT_W-1:0];
    end
    if (wr && (paddr == OFF_INT_EN)) begin
      int_en_d = pwdata[INT_W-1:0];
    end
    if (acc && !pready_q) begin
      case (paddr)
        OFF_INT_STS: prdata_d = {30'h0, sts};
        OFF_INT_EN:  prdata_d = {30'h0, int_en_q};
        OFF_CMD_A:   prdata_d = {ioc_q, 5'h00, align_q, 3'h0, ofs_q, 2'h0,
                                 first_q, ls_q, 1'b0, size_q};
        OFF_SUM:     prdata_d = {18'h0, state_q, sum_q};
        default:     pslverr_d = 1'b1;                 // Unmapped address
      endcase
    end
    // Interrupt only for enabled flags
    irq_d = |(sts & int_en_q);
  end

  // APB and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= INT_EN_RST;
      prdata_q <= ZERO32;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      int_en_q <= int_en_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // Checks; they assume ce stays high
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_done_flag: assert property (ce && din_valid && state_q == ST_DATA && ioc_q
      && (dw_q + 11'h001) == words_q |=> sts[INT_DONE])
    else $error("buffer done flag not set");
  chk_irq_masked: assert property (ce && (sts & int_en_q) == '0 |=> !irq_q)
    else $error("interrupt raised while masked");
  chk_irq_raised: assert property (ce && |(sts & int_en_q) |=> irq_q)
    else $error("enabled flag gave no interrupt");
  chk_pad_dropped: assert property (ce && din_valid && state_q == ST_DATA
      && {dw_q, 2'b00} >= 13'(end_q) |=> !out_valid_q)
    else $error("filler dword reached output");
  chk_lane_start: assert property (ce && din_valid && state_q == ST_DATA && !bad_q
      && dw_q == 11'(ofs_q[4:2]) && ofs_q[1:0] == 2'b11 && size_q != 11'h0
      |=> out_valid_q && out_be_q == 4'h8)
    else $error("wrong first byte lane");
  chk_dword_skip: assert property (ce && din_valid && state_q == ST_DATA
      && 13'({dw_q, 2'b11}) < 13'(ofs_q) |=> !out_valid_q)
    else $error("skipped dword was sent");
  chk_first_seg: assert property (out_valid_q && out_sof_q |-> first_q)
    else $error("start of frame without first segment");
  chk_sum_error: assert property (ce && din_valid && state_q == ST_CMD_B && ls_q
      && sum_q != 12'(din_data[SIZE_HI:0]) |=> sts[INT_ERR])
    else $error("length mismatch not flagged");
  chk_cmd_no_data: assert property (ce && din_valid && state_q != ST_DATA
      |=> !out_valid_q)
    else $error("command word passed as data");
  chk_rsv_align: assert property (ce && din_valid && state_q == ST_CMD_A
      && din_data[ALIGN_HI:ALIGN_LO] == ALIGN_RSV |=> sts[INT_ERR] ##0 bad_q)
    else $error("reserved alignment not flagged");
endmodule // tca_decoder

// *** include/tca_pkg.sv ***
// Purpose: Shared constants and types for the transmit command word A decoder
// Assumes: 32-bit command and data words, APB register access
// Notes:   Byte offsets of the APB registers are word aligned
package tca_pkg;
  // Command word A field positions
  localparam int IOC_BIT   = 31;
  localparam int ALIGN_HI  = 25;
  localparam int ALIGN_LO  = 24;
  localparam int OFS_HI    = 20;
  localparam int OFS_LO    = 16;
  localparam int FIRST_SEG_BIT = 13;
  localparam int LS_BIT    = 12;
  localparam int SIZE_HI   = 10;
  // End alignment encodings
  localparam logic [1:0] ALIGN_4   = 2'h0;
  localparam logic [1:0] ALIGN_16  = 2'h1;
  localparam logic [1:0] ALIGN_32  = 2'h2;
  localparam logic [1:0] ALIGN_RSV = 2'h3;
  // Dword rounding masks per alignment
  localparam logic [10:0] DW_MASK_4  = 11'h000;
  localparam logic [10:0] DW_MASK_16 = 11'h003;
  localparam logic [10:0] DW_MASK_32 = 11'h007;
  // APB register byte offsets
  localparam logic [7:0] OFF_INT_STS = 8'h00;
  localparam logic [7:0] OFF_INT_EN  = 8'h04;
  localparam logic [7:0] OFF_CMD_A   = 8'h08;
  localparam logic [7:0] OFF_SUM     = 8'h0c;
  // Interrupt status bit positions
  localparam int INT_DONE = 0;
  localparam int INT_ERR  = 1;
  localparam int INT_W    = 2;
  // Reset values
  localparam logic [1:0]  INT_EN_RST = 2'h0;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_DATA} tca_state_type;
endpackage

// *** core/tca_sticky.sv ***
// Purpose: Sticky event flags, cleared by writing one
// Assumes: Set and clear are one-cycle pulses in the pclk domain
// Notes:   A set in the clear cycle wins so no event is lost
`timescale 1ns/100ps
module tca_sticky
  import tca_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flag_q
);
  logic [W-1:0] flag_d;

  // Set dominates clear
  always_comb begin
    flag_d = (flag_q & ~clr) | set;
  end

  // Flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end
endmodule // tca_sticky

// *** sim/tca_host_model.sv ***
// Purpose: Host that writes command words and buffer data into the TX stream
// Assumes: One dword per cycle, driven just after the rising edge
// Notes:   Released data bus shows the inverse of its last value
`timescale 1ns/100ps
module tca_host_model (
  input  wire logic        pclk,
  output logic             din_valid,
  output logic      [31:0] din_data
);
  // Idle at time zero
  initial begin
    din_valid = 1'b0;
    din_data  = 32'h0000_0000;
  end

  // Command A, command B, then payload and filler dwords back to back
  task automatic send(input logic [31:0] a, input logic [31:0] b, input int n);
    @(posedge pclk);
    din_valid <= 1'b1;
    din_data  <= a;
    @(posedge pclk);
    din_data <= b;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      din_data <= 32'hd0d0_0000 + 32'(i);
    end
    @(posedge pclk);
    din_valid <= 1'b0;
    din_data  <= ~din_data; // Stale data would hide a late sample
  endtask
endmodule // tca_host_model

// *** sim/tb_tca_decoder.sv ***
// Purpose: Self-checking bench for the command word A decoder
// Assumes: ce high except in the freeze scenario; APB master waits for pready_q
// Notes:   Output dwords are captured as {sof, eof, be, data}
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_tca_decoder;
  import tca_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, din_valid, pready_q, pslverr_q;
  logic        out_valid_q, out_sof_q, out_eof_q, irq_q, err, ce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_q, din_data, out_data_q, rd;
  logic [3:0]  out_be_q;
  logic [37:0] got_q[$];
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  tca_decoder tca_decoder_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .din_valid(din_valid), .din_data(din_data),
    .out_valid_q(out_valid_q), .out_data_q(out_data_q), .out_be_q(out_be_q),
    .out_sof_q(out_sof_q), .out_eof_q(out_eof_q), .irq_q(irq_q));
  tca_host_model tca_host_model_inst (.pclk(pclk), .din_valid(din_valid), .din_data(din_data));

  // Capture every emitted dword
  always @(posedge pclk) begin
    if (out_valid_q === 1'b1) got_q.push_back({out_sof_q, out_eof_q, out_be_q, out_data_q});
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer, held until pready_q is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees pready_q
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read status, compare, then clear both flags
  task automatic sts_chk(input logic [31:0] e);
    apb(1'b0, OFF_INT_STS, 32'h0);
    `CHK(rd, e)
    apb(1'b1, OFF_INT_STS, 32'h3);
  endtask

  function automatic logic [31:0] cmd_a(logic ioc, logic [1:0] al, logic [4:0] ofs,
                                        logic first, logic last, logic [10:0] sz);
    return {ioc, 5'h00, al, 3'h0, ofs, 2'h0, first, last, 1'b0, sz};
  endfunction

  task automatic buf_run(input logic [31:0] a, input logic [10:0] len, input int n,
                         input int nexp);
    got_q.delete();
    tca_host_model_inst.send(a, {21'h0, len}, n);
    repeat (3) @(posedge pclk);
    `CHK(got_q.size(), nexp)
  endtask

  task automatic chk_out(input int i, input logic [37:0] e);
    `CHK(got_q[i], e)
  endtask

  task automatic t_regs();
    apb(1'b0, OFF_INT_EN, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, OFF_INT_EN, 32'hffff_ffff);
    apb(1'b0, OFF_INT_EN, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b1, OFF_INT_EN, 32'h0);
    sts_chk(32'h0);
  endtask

  // Clock enable low must hold the APB answer back until it returns
  task automatic t_freeze();
    ce <= 1'b0;
    fork
      apb(1'b0, OFF_INT_EN, 32'h0);
      begin
        repeat (5) @(posedge pclk);
        `CHK(pready_q, 1'b0)
        ce <= 1'b1;
      end
    join
    `CHK(rd, 32'h0)
  endtask

  task automatic t_walk();
    buf_run(cmd_a(1'b1, ALIGN_4, 5'h01, 1'b1, 1'b1, 11'h006), 11'h006, 2, 2);
    chk_out(0, {1'b1, 1'b0, 4'he, 32'hd0d0_0000});
    chk_out(1, {1'b0, 1'b1, 4'h7, 32'hd0d0_0001});
    apb(1'b0, OFF_CMD_A, 32'h0);
    `CHK(rd, cmd_a(1'b1, ALIGN_4, 5'h01, 1'b1, 1'b1, 11'h006))
    apb(1'b0, OFF_SUM, 32'h0);
    `CHK(rd, 32'h0000_0006)
    `CHK(irq_q, 1'b0)
    apb(1'b1, OFF_INT_EN, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq_q, 1'b1)
    sts_chk(32'h1);
    repeat (2) @(posedge pclk);
    `CHK(irq_q, 1'b0)
  endtask

  task automatic t_align();
    buf_run(cmd_a(1'b0, ALIGN_16, 5'h05, 1'b1, 1'b1, 11'h004), 11'h004, 4, 2);
    chk_out(0, {1'b1, 1'b0, 4'he, 32'hd0d0_0001});
    chk_out(1, {1'b0, 1'b1, 4'h1, 32'hd0d0_0002});
    buf_run(cmd_a(1'b0, ALIGN_32, 5'h1c, 1'b1, 1'b1, 11'h001), 11'h001, 8, 1);
    chk_out(0, {1'b1, 1'b1, 4'h1, 32'hd0d0_0007});
    buf_run(cmd_a(1'b0, ALIGN_4, 5'h03, 1'b1, 1'b1, 11'h002), 11'h002, 2, 2);
    chk_out(0, {1'b1, 1'b0, 4'h8, 32'hd0d0_0000});
    chk_out(1, {1'b0, 1'b1, 4'h1, 32'hd0d0_0001});
    sts_chk(32'h0);
  endtask

  task automatic t_errs();
    buf_run(cmd_a(1'b0, ALIGN_4, 5'h00, 1'b1, 1'b0, 11'h003), 11'h005, 1, 1);
    chk_out(0, {1'b1, 1'b0, 4'h7, 32'hd0d0_0000});
    buf_run(cmd_a(1'b0, ALIGN_4, 5'h00, 1'b0, 1'b1, 11'h002), 11'h005, 1, 1);
    chk_out(0, {1'b0, 1'b1, 4'h3, 32'hd0d0_0000});
    sts_chk(32'h0);
    buf_run(cmd_a(1'b0, ALIGN_4, 5'h00, 1'b1, 1'b1, 11'h006), 11'h005, 2, 2);
    `CHK(irq_q, 1'b0)
    sts_chk(32'h2);
    buf_run(cmd_a(1'b0, ALIGN_RSV, 5'h00, 1'b1, 1'b1, 11'h004), 11'h004, 1, 0);
    sts_chk(32'h2);
  endtask

  // Free-running clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Reset for four cycles, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_freeze();
    t_walk();
    t_align();
    t_errs();
    conclude();
  end
endmodule // tb_tca_decoder
